/* File: logic/ilp_pkg.sv */
package ilp_pkg;
    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_ACC0 = 8'h80;
    localparam logic [ADDR_W-1:0] OFS_ACC1 = 8'h84;
    localparam logic [ADDR_W-1:0] OFS_ADD0 = 8'h88;
    localparam logic [ADDR_W-1:0] OFS_ADD1 = 8'h8C;
    localparam logic [ADDR_W-1:0] OFS_ADD2 = 8'h90;
    localparam logic [ADDR_W-1:0] OFS_POP0 = 8'h94;
    localparam logic [ADDR_W-1:0] OFS_POP1 = 8'h98;
    localparam logic [ADDR_W-1:0] OFS_POPF = 8'h9C;
    localparam logic [ADDR_W-1:0] OFS_PEEK0 = 8'hA0;
    localparam logic [ADDR_W-1:0] OFS_PEEK1 = 8'hA4;
    localparam logic [ADDR_W-1:0] OFS_PEEKF = 8'hA8;
    localparam logic [ADDR_W-1:0] OFS_CTRL0 = 8'hAC;
    localparam logic [ADDR_W-1:0] OFS_CTRL1 = 8'hB0;

    // ------------------------------------------------------------
    // Field positions and constants
    // ------------------------------------------------------------
    localparam int CTRL_W = 21;
    localparam int POS_MIX = 21;
    localparam int POS_FORCE = 28;
    localparam int ALPHA_W = 8;
    localparam logic [4:0] TOP_POS = 5'h1F;
    localparam logic [DATA_W-1:0] ALL_ONES = 32'hFFFFFFFF;
    localparam logic [DATA_W-1:0] ZERO_W = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] force_top;
        logic bypass;
        logic swap_result;
        logic swap_input;
        logic twos;
        logic [4:0] top;
        logic [4:0] bottom;
        logic [4:0] shift;
    } ilp_lane_ctrl_s;

    typedef struct packed {
        logic [DATA_W-1:0] sm;
        logic [DATA_W-1:0] raw;
        logic overflow;
    } ilp_lane_out_s;

    typedef struct packed {
        logic [1:0][DATA_W-1:0] accum;
        logic [2:0][DATA_W-1:0] addend;
        logic [1:0][CTRL_W-1:0] ctrl;
        logic mix;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] awaddr;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } ilp_state_s;
endpackage

/* File: logic/ilp_interp.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
// What this block does
// (RQ1) Two resettable read/write accumulators
// (RQ2) Three resettable read/write addend registers
// (RQ3) Consume read returns result, reloads both accumulators
// (RQ4) Inspect read returns result, changes nothing
// (RQ5) Combined overflow is OR of both
// (RQ6) Per-accumulator overflow flags bits above mask
// (RQ7) Mix mode: lane one interpolates addends
// (RQ8) Mix mode: lane zero gives alpha only
// (RQ9) Mix mode: full omits lane one value
// (RQ10) Interpolation signedness from lane one; first only
// (RQ11) Force bits ORed into result bits 29:28
// (RQ12) Bypass uses raw input for lane result
// (RQ13) Swap result feeds opposite result on consume
// (RQ14) Swap input takes opposite accumulator, before bypass
// (RQ15) Two's complement sign-extends masked value
// (RQ16) Mask top bit inclusive
// (RQ17) Mask bottom bit inclusive, lower zeroed
// (RQ18) Software keeps top not below bottom
// (RQ19) Logical right shift before masking
// (RQ20) Normal lane and full result sums
// (RQ21) Own result reload; single-beat register access
// (RQ22) Lane one mirrors lane zero, own control
module ilp_interp
    import ilp_pkg::*;
#(
    parameter bit HAS_MIX = 1'b1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Word-aligned form of a byte address
    function automatic logic [ADDR_W-1:0] word_of(input logic [ADDR_W-1:0] a);
        word_of = {a[ADDR_W-1:2], 2'b00};
    endfunction

    // Byte-lane merge of a write into an old value
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v, input logic [DATA_W-1:0] new_v,
                                                input logic [STRB_W-1:0] strb);
        merge = old_v;
        for (int b = 0; b < STRB_W; b++) begin
            if (strb[b]) begin
                merge[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
    endfunction

    // Shift, mask, sign and bypass stage of one lane
    function automatic ilp_lane_out_s lane_calc(input logic [DATA_W-1:0] src, input ilp_lane_ctrl_s c);
        logic [DATA_W-1:0] shifted;
        logic [DATA_W-1:0] keep_low;
        logic [DATA_W-1:0] keep_high;
        logic [DATA_W-1:0] masked;
        shifted = src >> c.shift; // RQ19
        keep_low = ALL_ONES >> (TOP_POS - c.top); // RQ16
        keep_high = ALL_ONES << c.bottom; // RQ17
        masked = shifted & keep_low & keep_high;
        lane_calc.overflow = |(shifted & ~keep_low); // RQ6
        if (c.twos && masked[c.top]) begin
            lane_calc.sm = masked | ~keep_low; // RQ15
        end else begin
            lane_calc.sm = masked;
        end
        lane_calc.raw = c.bypass ? src : lane_calc.sm; // RQ12 RQ14
    endfunction

    // ------------------------------------------------------------
    // State and datapath
    // ------------------------------------------------------------
    ilp_state_s st;
    ilp_state_s next_st;
    ilp_lane_ctrl_s ctl0;
    ilp_lane_ctrl_s ctl1;
    ilp_lane_out_s lo0;
    ilp_lane_out_s lo1;
    logic mix_on;
    logic [DATA_W:0] ext0;
    logic [DATA_W:0] ext1;
    logic signed [DATA_W:0] diff;
    logic signed [DATA_W+ALPHA_W+1:0] prod;
    logic [DATA_W-1:0] blended;
    logic [DATA_W-1:0] res0;
    logic [DATA_W-1:0] res1;
    logic [DATA_W-1:0] full;
    logic [DATA_W-1:0] bus0;
    logic [DATA_W-1:0] bus1;
    logic [DATA_W-1:0] ctrl0_word;
    logic [DATA_W-1:0] ctrl1_word;
    logic ar_take;
    logic aw_take;
    logic w_take;
    logic commit;
    logic [ADDR_W-1:0] ar_word;
    logic [ADDR_W-1:0] aw_word;
    logic is_pop;
    logic [DATA_W-1:0] rd_val;
    logic rd_hit;
    logic wr_hit;
    logic [DATA_W-1:0] wr_val;

    // Lane inputs, with optional cross-feed ahead of the bypass
    always_comb begin
        ctl0 = ilp_lane_ctrl_s'(st.ctrl[0]);
        ctl1 = ilp_lane_ctrl_s'(st.ctrl[1]); // RQ22
        lo0 = lane_calc(ctl0.swap_input ? st.accum[1] : st.accum[0], ctl0); // RQ14
        lo1 = lane_calc(ctl1.swap_input ? st.accum[0] : st.accum[1], ctl1); // RQ14 RQ22
    end

    // Interpolation between addend zero and one
    always_comb begin
        mix_on = HAS_MIX && st.mix; // RQ10
        ext0 = {ctl1.twos & st.addend[0][DATA_W-1], st.addend[0]}; // RQ10
        ext1 = {ctl1.twos & st.addend[1][DATA_W-1], st.addend[1]};
        diff = $signed(ext1) - $signed(ext0);
        prod = diff * $signed({1'b0, lo1.sm[ALPHA_W-1:0]}); // RQ7
        blended = st.addend[0] + prod[ALPHA_W +: DATA_W];
    end

    // Lane and full results, with force bits on the bus copies only
    always_comb begin
        res0 = mix_on ? {{(DATA_W-ALPHA_W){1'b0}}, lo1.sm[ALPHA_W-1:0]} : lo0.raw + st.addend[0]; // RQ8 RQ20
        res1 = mix_on ? blended : lo1.raw + st.addend[1]; // RQ7 RQ20
        full = st.addend[2] + lo0.sm + (mix_on ? ZERO_W : lo1.sm); // RQ9 RQ20
        bus0 = res0 | (DATA_W'(ctl0.force_top) << POS_FORCE); // RQ11
        bus1 = res1 | (DATA_W'(ctl1.force_top) << POS_FORCE); // RQ11
        ctrl0_word = {6'h00, lo0.overflow | lo1.overflow, lo1.overflow, lo0.overflow, 1'b0, mix_on, ctl0}; // RQ5 RQ6
        ctrl1_word = {11'h000, ctl1};
    end

    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    assign s_axi_awready = !st.aw_held && !st.bvalid;
    assign s_axi_wready = !st.w_held && !st.bvalid;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    // Take conditions and address decode
    always_comb begin
        aw_take = s_axi_awvalid && s_axi_awready;
        w_take = s_axi_wvalid && s_axi_wready;
        ar_take = s_axi_arvalid && s_axi_arready;
        commit = st.aw_held && st.w_held;
        ar_word = word_of(s_axi_araddr);
        aw_word = word_of(st.awaddr);
        is_pop = ar_word == OFS_POP0 || ar_word == OFS_POP1 || ar_word == OFS_POPF;
    end

    // Read value selection
    always_comb begin
        rd_hit = 1'b1;
        unique case (ar_word)
            OFS_ACC0: rd_val = st.accum[0];
            OFS_ACC1: rd_val = st.accum[1];
            OFS_ADD0: rd_val = st.addend[0];
            OFS_ADD1: rd_val = st.addend[1];
            OFS_ADD2: rd_val = st.addend[2];
            OFS_POP0, OFS_PEEK0: rd_val = bus0; // RQ3 RQ4
            OFS_POP1, OFS_PEEK1: rd_val = bus1; // RQ3 RQ4
            OFS_POPF, OFS_PEEKF: rd_val = full; // RQ3 RQ4
            OFS_CTRL0: rd_val = ctrl0_word;
            OFS_CTRL1: rd_val = ctrl1_word;
            default: begin
                rd_val = ZERO_W;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Next state: channel capture, consume reload, then writes
    always_comb begin
        next_st = st;
        wr_hit = 1'b1;
        wr_val = ZERO_W;
        if (aw_take) begin
            next_st.aw_held = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (w_take) begin
            next_st.w_held = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (ar_take) begin
            next_st.rvalid = 1'b1; // RQ21
            next_st.rdata = rd_val;
            next_st.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
            if (is_pop) begin
                next_st.accum[0] = ctl0.swap_result ? res1 : res0; // RQ3 RQ13 RQ21
                next_st.accum[1] = ctl1.swap_result ? res0 : res1; // RQ3 RQ13 RQ21
            end
        end
        if (commit) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1; // RQ21
            unique case (aw_word)
                OFS_ACC0: begin
                    wr_val = merge(st.accum[0], st.wdata, st.wstrb);
                    next_st.accum[0] = wr_val; // RQ1
                end
                OFS_ACC1: begin
                    wr_val = merge(st.accum[1], st.wdata, st.wstrb);
                    next_st.accum[1] = wr_val; // RQ1
                end
                OFS_ADD0: begin
                    wr_val = merge(st.addend[0], st.wdata, st.wstrb);
                    next_st.addend[0] = wr_val; // RQ2
                end
                OFS_ADD1: begin
                    wr_val = merge(st.addend[1], st.wdata, st.wstrb);
                    next_st.addend[1] = wr_val; // RQ2
                end
                OFS_ADD2: begin
                    wr_val = merge(st.addend[2], st.wdata, st.wstrb);
                    next_st.addend[2] = wr_val; // RQ2
                end
                OFS_CTRL0: begin
                    wr_val = merge(ctrl0_word, st.wdata, st.wstrb);
                    next_st.ctrl[0] = wr_val[CTRL_W-1:0];
                    next_st.mix = HAS_MIX && wr_val[POS_MIX]; // RQ10
                end
                OFS_CTRL1: begin
                    wr_val = merge(ctrl1_word, st.wdata, st.wstrb);
                    next_st.ctrl[1] = wr_val[CTRL_W-1:0]; // RQ22
                end
                OFS_POP0, OFS_POP1, OFS_POPF, OFS_PEEK0, OFS_PEEK1, OFS_PEEKF: begin
                    wr_val = ZERO_W;
                end
                default: begin
                    wr_hit = 1'b0;
                end
            endcase
            next_st.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // State register with synchronous reset to zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0; // RQ1 RQ2
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence seq_pop_req;
        ar_take && is_pop && !commit;
    endsequence

    sequence seq_inspect_read_req;
        ar_take && !is_pop && !commit;
    endsequence

    a_pop_reload_zero: assert property (seq_pop_req |=> // RQ3
        st.accum[0] == ($past(ctl0.swap_result) ? $past(res1) : $past(res0)))
        else $error("consume read did not reload accumulator zero");

    a_pop_reload_one: assert property (seq_pop_req |=> // RQ13
        st.accum[1] == ($past(ctl1.swap_result) ? $past(res0) : $past(res1)))
        else $error("consume read did not reload accumulator one");

    a_inspect_read_no_change: assert property (seq_inspect_read_req |=> // RQ4
        $stable(st.accum) && $stable(st.addend) && $stable(st.ctrl))
        else $error("inspect read changed internal state");

    a_read_one_beat: assert property (ar_take |=> st.rvalid && st.rdata == $past(rd_val)) // RQ21
        else $error("read data not returned on the next cycle");

    a_write_one_beat: assert property (commit |=> st.bvalid && !st.aw_held && !st.w_held) // RQ21
        else $error("write response not given after both beats");

    a_overflow_or: assert property (ar_take && ar_word == OFS_CTRL0 |=> // RQ5
        st.rdata[POS_MIX+4] == (st.rdata[POS_MIX+3] | st.rdata[POS_MIX+2]))
        else $error("combined overflow is not the OR of both flags");

    a_force_bits: assert property (ar_take && (ar_word == OFS_PEEK0 || ar_word == OFS_POP0) |=> // RQ11
        st.rdata[POS_FORCE +: 2] == ($past(res0[POS_FORCE +: 2]) | $past(ctl0.force_top)))
        else $error("force bits missing from lane zero result");

    a_mix_lane_zero: assert property (mix_on && ar_take && ar_word == OFS_PEEK0 && ctl0.force_top == 2'h0 |=> // RQ8
        st.rdata == {{(DATA_W-ALPHA_W){1'b0}}, $past(lo1.sm[ALPHA_W-1:0])})
        else $error("mix mode lane zero result is not alpha only");

    a_full_sum: assert property (ar_take && ar_word == OFS_PEEKF |=> // RQ9
        st.rdata == $past(st.addend[2]) + $past(lo0.sm) + ($past(mix_on) ? ZERO_W : $past(lo1.sm)))
        else $error("full result sum wrong");

    a_unmapped_err: assert property (ar_take && !rd_hit |=> st.rresp == RESP_SLVERR)
        else $error("unmapped read not answered with error");

    a_resp_holds: assert property (st.bvalid && !s_axi_bready |=> st.bvalid [*1])
        else $error("write response dropped before it was taken");

    a_ctrl1_reserved: assert property (ar_take && ar_word == OFS_CTRL1 |=> // RQ22
        st.rdata[DATA_W-1:CTRL_W] == '0)
        else $error("lane one control reserved bits set");

    a_overflow_flags: assert property (ar_take && ar_word == OFS_CTRL0 |=> // RQ6
        st.rdata[POS_MIX+2] == $past(lo0.overflow) && st.rdata[POS_MIX+3] == $past(lo1.overflow))
        else $error("overflow flag wrong");

    a_read_holds: assert property (st.rvalid && !s_axi_rready |=> st.rvalid && $stable(st.rdata)) // RQ21
        else $error("read data dropped before taken");

    a_lane_one_sum: assert property ( // RQ20
        !mix_on && ar_take && ar_word == OFS_PEEK1 && ctl1.force_top == 2'h0 |=>
        st.rdata == $past(lo1.raw) + $past(st.addend[1]))
        else $error("lane one sum wrong");

    a_bypass_raw: assert property ( // RQ12 RQ14
        !mix_on && ar_take && ar_word == OFS_PEEK0 && ctl0.bypass && ctl0.force_top == 2'h0 |=>
        st.rdata == $past(ctl0.swap_input ? st.accum[1] : st.accum[0]) + $past(st.addend[0]))
        else $error("bypassed lane zero wrong");

    a_mask_low_zero: assert property (ctl0.top >= ctl0.bottom |-> // RQ17
        (lo0.sm & ~(ALL_ONES << ctl0.bottom)) == ZERO_W)
        else $error("bits below mask bottom set");

    a_mask_high_zero: assert property (ctl0.top >= ctl0.bottom && !ctl0.twos |-> // RQ16
        (lo0.sm & ~(ALL_ONES >> (TOP_POS - ctl0.top))) == ZERO_W)
        else $error("bits above mask top set");

    a_sign_fill: assert property (ctl0.top >= ctl0.bottom && ctl0.twos && lo0.sm[ctl0.top] |-> // RQ15
        (lo0.sm | (ALL_ONES >> (TOP_POS - ctl0.top))) == ALL_ONES)
        else $error("sign fill above mask top missing");

endmodule

/* File: logic/ilp_unused_placeholder_never.sv */
`timescale 1ns/100ps

/* File: tb/ilp_axi_host.sv */
`timescale 1ns/100ps
// Bus master standing in for the processor core
module ilp_axi_host
    import ilp_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Write channels
    output logic [ADDR_W-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [DATA_W-1:0] wdata,
    output logic [STRB_W-1:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [ADDR_W-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // Idle bus at time zero
    initial begin
        awaddr = '0;
        awvalid = 1'b0;
        wdata = '0;
        wstrb = '0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = '0;
        arvalid = 1'b0;
        rready = 1'b0;
    end

    // One write; response accepted after slow cycles, released payload shows inverted
    task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
            input logic [STRB_W-1:0] s, input int unsigned slow, output logic [1:0] r);
        int unsigned n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= (slow == 0);
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
                wstrb <= ~s;
            end
            if (n >= slow && !bready) bready <= 1'b1;
        end while (!(bvalid && bready));
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    // One read; data accepted after slow cycles
    task automatic read(input logic [ADDR_W-1:0] a, input int unsigned slow,
            output logic [DATA_W-1:0] d, output logic [1:0] r);
        int unsigned n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (slow == 0);
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (n >= slow && !rready) rready <= 1'b1;
        end while (!(rvalid && rready));
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
endmodule

/* File: tb/test_interpolator_lane_datapath.sv */
`timescale 1ns/100ps
module test_interpolator_lane_datapath
    import ilp_pkg::*;
;
    // Clock, reset, bus wires and reference state
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [STRB_W-1:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [DATA_W-1:0] acc [2] = '{default: '0};
    logic [DATA_W-1:0] add [3] = '{default: '0};
    logic [CTRL_W:0] ctl [2] = '{default: '0};
    logic [31:0] tbl [5] = '{32'h00007C00, 32'h0001FFFF, 32'h00209C08, 32'h00201C08, 32'h001E7C00};
    logic [31:0] seed = 32'h589E;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;

    always #5 aclk = ~aclk;

    ilp_interp ilp_interp_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    ilp_axi_host ilp_axi_host_inst (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // Repeatable xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] lane_in(int l);
        return ctl[l][16] ? acc[1-l] : acc[l];
    endfunction
    // Shifted, masked and optionally sign-extended lane value
    function automatic logic [31:0] lane_sm(int l);
        logic [63:0] s, keep, v;
        s = {32'h0, lane_in(l)} >> ctl[l][4:0];
        keep = ((64'h1 << (ctl[l][14:10] + 1)) - 1) & ~((64'h1 << ctl[l][9:5]) - 1);
        v = s & keep;
        if (ctl[l][15] && v[ctl[l][14:10]]) v = v | ~((64'h1 << (ctl[l][14:10] + 1)) - 1);
        return v[31:0];
    endfunction
    function automatic logic ovf(int l);
        logic [63:0] s;
        s = {32'h0, lane_in(l)} >> ctl[l][4:0];
        return |(s >> (ctl[l][14:10] + 1));
    endfunction
    // Lane result inside the datapath, mix_mode included
    function automatic logic [31:0] lane_res(int l);
        logic [31:0] t;
        logic [63:0] e0, e1;
        logic signed [63:0] p;
        t = lane_sm(1);
        if (ctl[0][21]) begin
            if (l == 0) return {24'h0, t[7:0]};
            e0 = ctl[1][15] ? {{32{add[0][31]}}, add[0]} : {32'h0, add[0]};
            e1 = ctl[1][15] ? {{32{add[1][31]}}, add[1]} : {32'h0, add[1]};
            p = $signed(e1 - e0) * $signed({56'h0, t[7:0]});
            p = p >>> 8;
            e0 = e0 + p;
            return e0[31:0];
        end
        return (ctl[l][18] ? lane_in(l) : lane_sm(l)) + add[l];
    endfunction
    function automatic logic [31:0] exp_rd(logic [7:0] a);
        case (a)
            OFS_ACC0: return acc[0];
            OFS_ACC1: return acc[1];
            OFS_ADD0: return add[0];
            OFS_ADD1: return add[1];
            OFS_ADD2: return add[2];
            OFS_POP0, OFS_PEEK0: return lane_res(0) | {2'b00, ctl[0][20:19], 28'h0};
            OFS_POP1, OFS_PEEK1: return lane_res(1) | {2'b00, ctl[1][20:19], 28'h0};
            OFS_POPF, OFS_PEEKF: return add[2] + lane_sm(0) + (ctl[0][21] ? 32'h0 : lane_sm(1));
            OFS_CTRL0: return {6'h0, ovf(0) | ovf(1), ovf(1), ovf(0), 1'b0, ctl[0]};
            OFS_CTRL1: return {11'h0, ctl[1][20:0]};
            default: return 32'h0;
        endcase
    endfunction
    function automatic logic [1:0] exp_resp(logic [7:0] a);
        return (a >= 8'h80 && a <= 8'hB0) ? RESP_OKAY : RESP_SLVERR;
    endfunction
    // Control value that keeps the mask top at or above its bottom
    function automatic logic [31:0] rnd_ctl();
        logic [31:0] v;
        v = rnd();
        if (v[14:10] < v[9:5]) v[14:10] = v[9:5];
        return v;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bus write, then the same write applied to the reference
    task automatic put(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        logic [1:0] r;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        ilp_axi_host_inst.write(a, d, s, rnd() % 3, r);
        check({30'h0, r}, {30'h0, exp_resp(a)});
        case (a)
            OFS_ACC0: acc[0] = (acc[0] & ~m) | (d & m);
            OFS_ACC1: acc[1] = (acc[1] & ~m) | (d & m);
            OFS_ADD0: add[0] = (add[0] & ~m) | (d & m);
            OFS_ADD1: add[1] = (add[1] & ~m) | (d & m);
            OFS_ADD2: add[2] = (add[2] & ~m) | (d & m);
            OFS_CTRL0: ctl[0] = (ctl[0] & ~m[21:0]) | (d[21:0] & m[21:0]);
            OFS_CTRL1: ctl[1] = {1'b0, (ctl[1][20:0] & ~m[20:0]) | (d[20:0] & m[20:0])};
            default: ;
        endcase
    endtask
    // Bus read compared with the reference; a consume read reloads both accumulators
    task automatic get(input logic [7:0] a);
        logic [31:0] e, d, r0, r1;
        logic [1:0] r;
        e = exp_rd(a);
        ilp_axi_host_inst.read(a, rnd() % 3, d, r);
        check(d, e);
        check({30'h0, r}, {30'h0, exp_resp(a)});
        r0 = lane_res(0);
        r1 = lane_res(1);
        if (a == OFS_POP0 || a == OFS_POP1 || a == OFS_POPF) begin
            acc[0] = ctl[0][17] ? r1 : r0;
            acc[1] = ctl[1][17] ? r0 : r1;
        end
    endtask

    task automatic complete_run();
        if (err_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            complete_run();
        end
    end

    // Reset, register sweep, refused places, then table and random traffic
    initial begin
        logic [31:0] v, c;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int a = 8'h80; a <= 8'hB4; a += 4) get(a[7:0]);
        get(8'h00);
        put(8'hFC, 32'h12345678, 4'hF);
        put(OFS_PEEK0, 32'hFFFFFFFF, 4'hF);
        for (int i = 0; i < 200; i++) begin
            c = (i < 5) ? tbl[i] : rnd_ctl();
            put(OFS_CTRL0, c, 4'hF);
            c = (i < 5) ? tbl[i] : rnd_ctl();
            put(OFS_CTRL1, c, 4'hF);
            put(OFS_ACC0, rnd(), 4'hF);
            put(OFS_ACC1, rnd(), 4'hF);
            for (int k = 0; k < 3; k++) begin
                v = rnd();
                put(8'(OFS_ADD0 + 4 * k), rnd(), v[3:0] | 4'(i < 5 ? 15 : 0));
            end
            repeat (8) begin
                v = rnd();
                get(8'(8'h80 + 4 * (v % 14)));
            end
        end
        complete_run();
    end
endmodule
